// ===== verilog/tsw_pkg.sv
// constants, field layout and types shared by the two-stage watchdog files
`default_nettype none

package tsw_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 25_000_000;
    localparam int unsigned QUARTER_MS = 250;
    localparam int unsigned QTR_CYCLES = CLK_HZ / 1000 * QUARTER_MS;
    localparam int          PRE_W      = 23;
    localparam int          PER_W      = 11;

    // ------------------------------------------------------------------
    // register map: index, byte address is index times four
    // ------------------------------------------------------------------
    localparam int          ADR_LSB    = 2;
    localparam logic [7:0]  IDX_CTRL   = 8'h79;
    localparam logic [7:0]  IDX_STAT   = 8'h7a;
    localparam logic [7:0]  IDX_MASK   = 8'h7b;

    // control register fields
    localparam int          CTL_SEL_LSB = 0;
    localparam int          CTL_SEL_MSB = 2;
    localparam int          CTL_S1EN    = 3;
    localparam int          CTL_S1INIT  = 4;
    localparam int          CTL_RSTEN   = 5;
    localparam int          CTL_CAUSEEN = 6;
    localparam int          CTL_CAUSE   = 7;
    localparam logic [7:0]  CTRL_RST    = 8'h00;

    // interrupt status and mask fields
    localparam int          IRQ_W       = 2;
    localparam int          IRQ_S1      = 0;
    localparam int          IRQ_RST     = 1;
    localparam logic [1:0]  IRQ_RSTVAL  = 2'h0;

    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b00,
        ST_ARMED  = 2'b01,
        ST_STAGE1 = 2'b10,
        ST_RESET  = 2'b11
    } tsw_state_t;

    typedef enum logic [1:0]
    {
        RS_NONE = 2'b00,
        RS_CTRL = 2'b01,
        RS_STAT = 2'b10,
        RS_MASK = 2'b11
    } tsw_rsel_t;

    // last value of the quarter-second count for each period code:
    // 0.25, 0.5, 1, 2, 8, 32, 128, 256 seconds
    function automatic logic [PER_W-1:0] tsw_period_last(input logic [2:0] sel);
        logic [PER_W-1:0] v;
        v = 11'h000;
        unique case (sel)
            3'h0: v = 11'h000;
            3'h1: v = 11'h001;
            3'h2: v = 11'h003;
            3'h3: v = 11'h007;
            3'h4: v = 11'h01f;
            3'h5: v = 11'h07f;
            3'h6: v = 11'h1ff;
            3'h7: v = 11'h3ff;
        endcase
        return v;
    endfunction

endpackage

`default_nettype wire

// ===== verilog/tsw_reg_if.sv
// register access path between the bus slave and the watchdog core
`default_nettype none

interface tsw_reg_if;
    import tsw_pkg::*;

    logic       wr;     // write strobe, one cycle at the acknowledging edge
    logic       rd;     // read strobe, one cycle at the acknowledging edge
    tsw_rsel_t  rsel;   // decoded register
    logic [7:0] wdata;  // write byte
    logic [7:0] rdata;  // read byte from the core
    logic [7:0] rcap;   // byte already handed to the master

    modport bus  (output wr, rd, rsel, wdata, rcap, input rdata);
    modport core (input wr, rd, rsel, wdata, rcap, output rdata);
endinterface

`default_nettype wire

// ===== verilog/tsw_downcnt.sv
// reloading down counter used for the prescaler and the period count
`default_nettype none

module tsw_downcnt #(
    parameter int W = 8
) (
    input  wire logic         clk_i,   // clock
    input  wire logic         rst_i,   // async power-up reset
    input  wire logic         ce_i,    // clock enable
    input  wire logic         load_i,  // restart from val_i
    input  wire logic [W-1:0] val_i,   // reload value
    input  wire logic         en_i,    // count step
    output logic      [W-1:0] cnt_o,   // current count
    output logic              done_o   // step taken at zero
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    assign done_o = ce_i & en_i & ~load_i & (cnt_ff == '0);
    assign cnt_o  = cnt_ff;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (load_i)
            nxt_cnt = val_i;
        else if (en_i)
            nxt_cnt = (cnt_ff == '0) ? val_i : cnt_ff - 1'b1;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_ff <= '0;
        else if (ce_i)
            cnt_ff <= nxt_cnt;
    end
endmodule

`default_nettype wire

// ===== verilog/tsw_wb_slave.sv
// classic wishbone slave for the watchdog register bytes
`default_nettype none

module tsw_wb_slave
    import tsw_pkg::*;
(
    input  wire logic        clk_i,  // clock
    input  wire logic        rst_i,  // async power-up reset
    input  wire logic        ce_i,   // clock enable
    input  wire logic        cyc_i,  // bus cycle
    input  wire logic        stb_i,  // strobe
    input  wire logic        we_i,   // write
    input  wire logic [31:0] adr_i,  // byte address
    input  wire logic [3:0]  sel_i,  // byte enables
    input  wire logic [31:0] dat_i,  // write data
    output logic      [31:0] dat_o,  // read data
    output logic             ack_o,  // acknowledge
    tsw_reg_if.bus           regs    // core side
);
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic        ack_ff;
    logic [31:0] dat_ff;
    wire         req      = cyc_i & stb_i;
    wire  [29:0] word     = adr_i[31:ADR_LSB];
    wire         hit_ctrl = (word == 30'(IDX_CTRL));
    wire         hit_stat = (word == 30'(IDX_STAT));
    wire         hit_mask = (word == 30'(IDX_MASK));

    assign regs.rsel  = hit_ctrl ? RS_CTRL : hit_stat ? RS_STAT : hit_mask ? RS_MASK : RS_NONE;
    // strobes fire at the edge where the master samples ack
    assign regs.wr    = ce_i & req & we_i & ack_ff & sel_i[0];
    assign regs.rd    = ce_i & req & ~we_i & ack_ff;
    assign regs.wdata = dat_i[7:0];
    assign regs.rcap  = dat_ff[7:0];
    assign dat_o      = dat_ff;
    assign ack_o      = ack_ff;

    // ------------------------------------------------------------------
    // answer one cycle after the request, unmapped reads return zero
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end
        else if (ce_i)
        begin
            ack_ff <= req & ~ack_ff;
            if (req & ~ack_ff & ~we_i)
                dat_ff <= 32'(regs.rdata);
        end
    end

    a_ctrl_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && ack_o && cyc_i && stb_i && we_i && sel_i[0] && word == 30'(IDX_CTRL))
        |-> (regs.wr && regs.rsel == RS_CTRL))
        else $error("control byte write not decoded");

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && ack_o) |=> !ack_o)
        else $error("ack held longer than one cycle");
endmodule

`default_nettype wire

// ===== verilog/tsw_top.sv
// two-stage watchdog: control byte, period timing, stage sequencing, interrupts
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`default_nettype none

module tsw_top
    import tsw_pkg::*;
#(
    parameter int unsigned QTR_CYC = QTR_CYCLES
) (
    input  wire logic        clk_i,        // 25 MHz clock
    input  wire logic        rst_i,        // async power-up reset, high
    input  wire logic        ce_i,         // clock enable, freezes all state
    input  wire logic        wb_cyc_i,     // wishbone cycle
    input  wire logic        wb_stb_i,     // wishbone strobe
    input  wire logic        wb_we_i,      // wishbone write
    input  wire logic [31:0] wb_adr_i,     // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,     // wishbone byte enables
    input  wire logic [31:0] wb_dat_i,     // wishbone write data
    output logic      [31:0] wb_dat_o,     // wishbone read data
    output logic             wb_ack_o,     // wishbone acknowledge
    input  wire logic        board_rst_i,  // board reset in progress, sync
    output logic             nmi_o,        // first stage nmi
    output logic             cpu_init_o,   // first stage cpu init
    output logic             rst_req_o,    // board reset request
    output logic             irq_o         // level interrupt
);
    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    tsw_reg_if regs ();

    tsw_wb_slave u_slave (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .cyc_i (wb_cyc_i),
        .stb_i (wb_stb_i),
        .we_i  (wb_we_i),
        .adr_i (wb_adr_i),
        .sel_i (wb_sel_i),
        .dat_i (wb_dat_i),
        .dat_o (wb_dat_o),
        .ack_o (wb_ack_o),
        .regs  (regs)
    );

    // ------------------------------------------------------------------
    // registers and decode
    // ------------------------------------------------------------------
    logic [7:0]       ctrl_ff;
    logic [IRQ_W-1:0] stat_ff;
    logic [IRQ_W-1:0] mask_ff;
    tsw_state_t       state_ff;
    logic             nmi_ff;
    logic             init_ff;
    logic             rstreq_ff;
    logic             irq_ff;

    logic [7:0]       nxt_ctrl;
    logic [IRQ_W-1:0] nxt_stat;
    logic [IRQ_W-1:0] nxt_mask;
    tsw_state_t       nxt_state;

    wire ctrl_wr = regs.wr & (regs.rsel == RS_CTRL);
    wire stat_rd = regs.rd & (regs.rsel == RS_STAT);
    wire mask_wr = regs.wr & (regs.rsel == RS_MASK);
    wire strobe  = ctrl_wr;

    // low control bits apart from the cause flag, so the flag's set path does not loop back
    wire [CTL_CAUSEEN:0] nxt_low = ctrl_wr ? regs.wdata[CTL_CAUSEEN:0] : ctrl_ff[CTL_CAUSEEN:0];
    wire n_s1en   = nxt_low[CTL_S1EN];
    wire n_rsten  = nxt_low[CTL_RSTEN];
    wire n_s1init = nxt_low[CTL_S1INIT];
    wire run      = n_s1en | n_rsten;

    wire counting = (state_ff == ST_ARMED) | (state_ff == ST_STAGE1);
    wire ev_s1    = (state_ff != ST_STAGE1) & (nxt_state == ST_STAGE1);
    wire ev_rst   = (state_ff != ST_RESET) & (nxt_state == ST_RESET);
    wire cause_w1 = ctrl_wr & regs.wdata[CTL_CAUSE];
    wire cause_st = ev_rst & ctrl_ff[CTL_CAUSEEN];

    assign regs.rdata = (regs.rsel == RS_CTRL) ? ctrl_ff :
                        (regs.rsel == RS_STAT) ? 8'(stat_ff) :
                        (regs.rsel == RS_MASK) ? 8'(mask_ff) : 8'h00;

    // cause flag: hardware set wins over a write-one clear
    assign nxt_ctrl = {(ctrl_ff[CTL_CAUSE] & ~cause_w1) | cause_st, nxt_low};
    // only bits already handed to the reader are cleared, new events survive
    assign nxt_stat = (stat_ff & ~(stat_rd ? regs.rcap[IRQ_W-1:0] : IRQ_RSTVAL))
                    | {ev_rst, ev_s1};
    assign nxt_mask = mask_wr ? regs.wdata[IRQ_W-1:0] : mask_ff;

    // ------------------------------------------------------------------
    // timebase: quarter-second prescaler and period count
    // ------------------------------------------------------------------
    logic [PRE_W-1:0] pre_cnt;
    logic [PER_W-1:0] per_cnt;
    logic             tick;
    logic             expire;
    wire  [PER_W-1:0] per_last = tsw_period_last(nxt_low[CTL_SEL_MSB:CTL_SEL_LSB]);
    wire  [PRE_W-1:0] pre_last = PRE_W'(QTR_CYC - 1);
    // a strobe, a board reset, an idle watchdog or a pending reset request keep both counters at full
    wire              restart  = strobe | board_rst_i | (state_ff == ST_IDLE) | (state_ff == ST_RESET);

    tsw_downcnt #(.W(PRE_W)) u_pre (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .load_i (restart),
        .val_i  (pre_last),
        .en_i   (counting),
        .cnt_o  (pre_cnt),
        .done_o (tick)
    );

    tsw_downcnt #(.W(PER_W)) u_per (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .load_i (restart),
        .val_i  (per_last),
        .en_i   (tick),
        .cnt_o  (per_cnt),
        .done_o (expire)
    );

    // ------------------------------------------------------------------
    // stage sequencing
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:
                nxt_state = ST_ARMED;
            ST_ARMED:
                if (strobe)
                    nxt_state = ST_ARMED;
                else if (expire)
                    nxt_state = n_s1en ? ST_STAGE1 : ST_RESET;
            ST_STAGE1:
                if (strobe)
                    nxt_state = ST_ARMED;
                else if (expire && n_rsten)
                    nxt_state = ST_RESET;
            ST_RESET:
                // a late strobe that leaves a stage enabled cannot withdraw a request already made
                if (board_rst_i)
                    nxt_state = ST_ARMED;
        endcase
        if (!run)
            nxt_state = ST_IDLE;
    end

    // ------------------------------------------------------------------
    // flip-flops; board reset leaves the control byte alone
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_ff  <= CTRL_RST;
            stat_ff  <= IRQ_RSTVAL;
            mask_ff  <= IRQ_RSTVAL;
            state_ff <= ST_IDLE;
        end
        else if (ce_i)
        begin
            ctrl_ff  <= nxt_ctrl;
            stat_ff  <= nxt_stat;
            mask_ff  <= nxt_mask;
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            nmi_ff    <= 1'b0;
            init_ff   <= 1'b0;
            rstreq_ff <= 1'b0;
            irq_ff    <= 1'b0;
        end
        else if (ce_i)
        begin
            nmi_ff    <= (nxt_state == ST_STAGE1) & ~n_s1init;
            init_ff   <= (nxt_state == ST_STAGE1) & n_s1init;
            rstreq_ff <= (nxt_state == ST_RESET);
            irq_ff    <= |(nxt_stat & nxt_mask);
        end
    end

    assign nmi_o      = nmi_ff;
    assign cpu_init_o = init_ff;
    assign rst_req_o  = rstreq_ff;
    assign irq_o      = irq_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_expire_armed;
        ce_i && state_ff == ST_ARMED && expire && !strobe && run;
    endsequence

    sequence s_expire_stage1;
        ce_i && state_ff == ST_STAGE1 && expire && !strobe && n_rsten;
    endsequence

    a_period_load: assert property (
        (ce_i && strobe && run) |=> (per_cnt == tsw_period_last(ctrl_ff[CTL_SEL_MSB:CTL_SEL_LSB])))
        else $error("period count not loaded from the selected code");

    a_idle_quiet: assert property (
        (ce_i && !run) |=> (state_ff == ST_IDLE) ##1 (!nmi_o && !cpu_init_o && !rst_req_o))
        else $error("inactive watchdog took an action");

    a_stage_order: assert property (
        s_expire_stage1 |=> rst_req_o && !nmi_o && !cpu_init_o && $past(nmi_o || cpu_init_o))
        else $error("reset request not preceded by the first stage");

    a_first_stage: assert property (
        (s_expire_armed and (n_s1en && !strobe)) |=> (nmi_o != cpu_init_o) && !rst_req_o)
        else $error("first stage missing after expiry");

    a_reset_only: assert property (
        (s_expire_armed and (!n_s1en)) |=> rst_req_o && !nmi_o)
        else $error("reset request missing after expiry");

    a_cause_set: assert property (
        (ce_i && $rose(rst_req_o) && $past(ctrl_ff[CTL_CAUSEEN])) |-> ctrl_ff[CTL_CAUSE])
        else $error("cause flag not recorded");

    a_cause_hold: assert property (
        (ce_i && board_rst_i && !ctrl_wr) |=> ctrl_ff == ($past(ctrl_ff) | $past({cause_st, 7'h00})))
        else $error("board reset disturbed the control byte");

    a_strobe_restart: assert property (
        (ce_i && strobe && run) |=> (pre_cnt == pre_last && !tick) ##1 !tick)
        else $error("strobe did not restart the full period");

    a_irq_level: assert property (
        (ce_i && stat_rd && !(ev_s1 || ev_rst)) |=> ##1 (irq_o == |(stat_ff & mask_ff)))
        else $error("interrupt level disagrees with status and mask");
endmodule

`default_nettype wire

// ===== testbench/tsw_top_test.sv
// self-checking bench for the two-stage watchdog
`default_nettype none

module tsw_top_test
    import tsw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------------
    // short quarter so that the 256 s period stays a few thousand cycles
    localparam int Q = 8;

    logic        clk_i;
    logic        rst_i;
    logic        ce_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [31:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        board_rst_i;
    logic        nmi_o;
    logic        cpu_init_o;
    logic        rst_req_o;
    logic        irq_o;
    int          n_fail;
    int          cmp_count;
    integer      seed;
    logic [7:0]  rd;
    int          n;
    int          c;
    int          m;

    tsw_top #(.QTR_CYC(Q)) tsw_top_i (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .wb_cyc_i    (wb_cyc_i),
        .wb_stb_i    (wb_stb_i),
        .wb_we_i     (wb_we_i),
        .wb_adr_i    (wb_adr_i),
        .wb_sel_i    (wb_sel_i),
        .wb_dat_i    (wb_dat_i),
        .wb_dat_o    (wb_dat_o),
        .wb_ack_o    (wb_ack_o),
        .board_rst_i (board_rst_i),
        .nmi_o       (nmi_o),
        .cpu_init_o  (cpu_init_o),
        .rst_req_o   (rst_req_o),
        .irq_o       (irq_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic int qt(input int code);
        int t [8] = '{1, 2, 4, 8, 32, 128, 512, 1024};
        return t[code];
    endfunction

    function automatic logic pick(input int w);
        logic [3:0] v;
        v = {irq_o, rst_req_o, cpu_init_o, nmi_o};
        return v[w];
    endfunction

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("unexpected at %0t ns: %s", $time, msg);
        end
    endtask

    // one classic cycle; the request stands until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {22'h0, idx, 2'b00};
        wb_dat_i <= {24'h0, wd};
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 16);
        if (wb_ack_o !== 1'b1)
        begin
            n_fail++;
            $display("unexpected at %0t ns: bus acknowledge missing", $time);
            stop_test();
        end
        rd = wb_dat_o[7:0];
        if (!we)
            chk(wb_dat_o[31:8] === 24'h0, "upper read bits not zero");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string msg);
        wb(1'b0, idx, 8'h00);
        chk(rd === exp, msg);
    endtask

    task automatic bpulse();
        @(posedge clk_i);
        board_rst_i <= 1'b1;
        @(posedge clk_i);
        board_rst_i <= 1'b0;
    endtask

    task automatic settle();
        wb(1'b1, IDX_CTRL, 8'h00);
        bpulse();
        wb(1'b0, IDX_STAT, 8'h00);
    endtask

    task automatic wait_out(input int w, input int lim);
        n = 0;
        while (pick(w) !== 1'b1 && n <= lim)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // n counts edges from the strobe, so one output flop and the arm step are allowed
    task automatic expire(input int w, input int q);
        wait_out(w, q * Q + 8);
        chk(n >= q * Q - 1 && n <= q * Q + 3, "timeout action at wrong time");
    endtask

    task automatic quiet(input int lim);
        repeat (lim)
        begin
            @(posedge clk_i);
            chk({nmi_o, cpu_init_o, rst_req_o} === 3'b000, "watchdog acted unexpectedly");
        end
    endtask

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        $display("unexpected at %0t ns: run limit reached", $time);
        stop_test();
    end

    initial
    begin
        seed = 32'h333d;
        n_fail = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 32'h0;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0;
        board_rst_i = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(IDX_CTRL, CTRL_RST, "control not clear");
        rdchk(IDX_STAT, 8'h00, "status not clear");
        rdchk(IDX_MASK, 8'h00, "mask not clear");
        rdchk(8'h55, 8'h00, "unmapped word not zero");
        $display("test power-up values done");
        c = $unsigned($random(seed)) % 4;
        wb(1'b1, IDX_CTRL, 8'h40 | 8'(c));
        quiet(2 * qt(c) * Q + 8);
        $display("test inactive watchdog done");
        for (c = 0; c < 8; c++)
        begin
            wb(1'b1, IDX_CTRL, 8'h20 | 8'(c));
            expire(2, qt(c));
            chk(nmi_o === 1'b0 && cpu_init_o === 1'b0, "first stage not enabled");
            wb(1'b1, IDX_CTRL, 8'h20 | 8'(c));
            @(posedge clk_i);
            chk(rst_req_o === 1'b1, "strobe dropped reset request");
            bpulse();
            @(posedge clk_i);
            chk(rst_req_o === 1'b0, "request held past board reset");
        end
        settle();
        $display("test eight periods done");
        for (m = 0; m < 3; m++)
        begin
            c = $unsigned($random(seed)) % 4;
            wb(1'b1, IDX_CTRL, (m == 2 ? 8'h08 : 8'h28) | (m == 1 ? 8'h10 : 8'h00) | 8'(c));
            expire(m == 1 ? 1 : 0, qt(c));
            chk(rst_req_o === 1'b0 && pick(m == 1 ? 0 : 1) === 1'b0, "wrong first stage line");
            if (m < 2)
                expire(2, qt(c));
            else
            begin
                repeat (2 * qt(c) * Q) @(posedge clk_i);
                chk(nmi_o === 1'b1 && rst_req_o === 1'b0, "lone first stage wrong");
                wb(1'b1, IDX_CTRL, 8'h08 | 8'(c));
                repeat (2) @(posedge clk_i);
                chk(nmi_o === 1'b0, "strobe did not end first stage");
            end
            settle();
        end
        $display("test two stages done");
        c = 1 + $unsigned($random(seed)) % 3;
        for (m = 0; m < 5; m++)
        begin
            wb(1'b1, IDX_CTRL, 8'h20 | 8'(c));
            quiet(qt(c) * Q - 8 + $unsigned($random(seed)) % 4);
        end
        wb(1'b1, IDX_CTRL, 8'h20 | 8'(c));
        expire(2, qt(c));
        settle();
        $display("test strobe restart done");
        wb(1'b1, IDX_CTRL, 8'h21);
        expire(2, 2);
        bpulse();
        rdchk(IDX_CTRL, 8'h21, "cause set while disabled");
        wb(1'b1, IDX_CTRL, 8'h61);
        expire(2, 2);
        bpulse();
        rdchk(IDX_CTRL, 8'he1, "cause lost over board reset");
        wb(1'b1, IDX_CTRL, 8'h80);
        rdchk(IDX_CTRL, 8'h00, "cause did not clear");
        settle();
        $display("test cause flag done");
        for (m = 0; m < 4; m++)
        begin
            wb(1'b1, IDX_MASK, 8'(m));
            rdchk(IDX_MASK, 8'(m), "mask readback");
            wb(1'b1, IDX_CTRL, 8'h28);
            expire(2, 2);
            repeat (2) @(posedge clk_i);
            chk(irq_o === (m != 0), "interrupt level wrong");
            rdchk(IDX_STAT, 8'h03, "status events missing");
            repeat (2) @(posedge clk_i);
            chk(irq_o === 1'b0, "interrupt after status read");
            settle();
        end
        $display("test interrupts done");
        wb(1'b1, IDX_CTRL, 8'h20);
        @(posedge clk_i);
        ce_i <= 1'b0;
        quiet(4 * Q);
        ce_i <= 1'b1;
        expire(2, 1);
        settle();
        $display("test clock enable freeze done");
        wb(1'b1, IDX_MASK, 8'h03);
        wb(1'b1, IDX_CTRL, 8'h6b);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(IDX_CTRL, 8'h00, "control survived power-up");
        rdchk(IDX_MASK, 8'h00, "mask survived power-up");
        $display("test power-up mid run done");
        stop_test();
    end
endmodule

`default_nettype wire
